/* File: hw/lcerr_pkg.sv */
// constants and types of the primary cache error latch
// Notes on behaviour
// - latch tag, cache data, bus data parity, bus error, accelerator errors
// - report each error as level 1a soft interrupt or machine check
// - cache is disabled while first trap, repeat trap or interrupt set
// - tag parity needs read/write/invalidate, cache on, no force hit, no lock
// - tag parity always interrupts; data-stream read hit adds machine check
// - cache data parity only on read hit, never while force hit set
// - data parity: data read gives machine check, instruction read interrupt
// - bus data parity only on non-io reads that missed the cache
// - requested longword of data read traps; other longword interrupts
// - bus error on read, write, buffer clear: traps, instruction read interrupts
// - bus error on register or vector read never locks the status
// - accelerator result parity error is always a machine check
// - interrupt error sets bit 5 and loads description bits 12:8
// - description kept when interrupt or first trap already set
// - trap error sets first trap, loads description and error address
// - trap while first trap set: set repeat trap, keep description, address
// - trap description overwrites one captured for an interrupt
// - backup hit loaded only on bus data parity and bus error, zero for all other errors
// - bus data parity ignored on a read ended by bus error
// - commands with detection inhibited set no trap or interrupt flag
package lcerr_pkg;
    localparam int             STS_W     = 13;
    localparam int             ADDR_W    = 30;
    localparam int             DATA_W    = 32;
    localparam int             DESC_W    = 5;
    localparam int             BIT_FHT   = 0;
    localparam int             BIT_PON   = 1;
    localparam int             BIT_FLS   = 2;
    localparam int             BIT_RFR   = 3;
    localparam int             BIT_HIT   = 4;
    localparam int             BIT_INT   = 5;
    localparam int             BIT_TR2   = 6;
    localparam int             BIT_TR1   = 7;
    localparam int             DESC_LSB  = 8;
    // description field values
    localparam logic [4:0]     DESC_TAG  = 5'h01;
    localparam logic [4:0]     DESC_DDP  = 5'h02;
    localparam logic [4:0]     DESC_PDP  = 5'h04;
    localparam logic [4:0]     DESC_BER  = 5'h08;
    localparam logic [4:0]     DESC_BCH  = 5'h10;
    localparam logic [4:0]     DESC_RST  = 5'h00;
    localparam logic [4:0]     SOFT_IPL  = 5'h1a;
    localparam logic [31:0]    DATA_ZERO = 32'h0000_0000;
    typedef enum logic [3:0] {
        CMD_D_READ,
        CMD_I_READ,
        CMD_WRITE,
        CMD_INVAL,
        CMD_CLR_WBUF,
        CMD_EPR_READ,
        CMD_EPR_WRITE,
        CMD_IVEC_READ,
        CMD_RSLT_XFER,
        CMD_OTHER
    } lcerr_cmd_t;
    function automatic logic lcerr_is_read(input lcerr_cmd_t c);
        return (c == CMD_D_READ) || (c == CMD_I_READ);
    endfunction
endpackage

/* File: hw/lcerr_classify.sv */
// sorts one reference's error signals into trap and interrupt classes
`timescale 1ns/1ps
`default_nettype none
module lcerr_classify import lcerr_pkg::*; (
    input  wire logic       i_ref_valid,
    input  wire lcerr_cmd_t i_cmd,
    input  wire logic       i_io,
    input  wire logic       i_pc_hit,
    input  wire logic       i_bc_hit,
    input  wire logic       i_tag_perr,
    input  wire logic       i_data_perr,
    input  wire logic       i_bus_perr_req,
    input  wire logic       i_bus_perr_oth,
    input  wire logic       i_bus_err,
    input  wire logic       i_fpa_perr,
    input  wire logic       i_cache_en,
    input  wire logic       i_force_hit,
    input  wire logic       i_locked,
    output logic            o_mchk,
    output logic            o_intr,
    output logic [4:0]      o_desc_m,
    output logic [4:0]      o_desc_i
);
    logic rd, drd, ird, tag, dat, bpe, bpe_m, bpe_i, ber_m, ber_i;
    logic [4:0] backup_hit_flag;
    always_comb begin
        rd    = lcerr_is_read(i_cmd);
        drd   = i_cmd == CMD_D_READ;
        ird   = i_cmd == CMD_I_READ;
        backup_hit_flag   = i_bc_hit ? DESC_BCH : DESC_RST;
        tag   = i_ref_valid & i_tag_perr & i_cache_en & ~i_force_hit
              & ~i_locked & (rd | i_cmd == CMD_WRITE
              | i_cmd == CMD_INVAL);
        dat   = i_ref_valid & i_data_perr & i_cache_en & ~i_force_hit
              & rd & i_pc_hit;
        bpe   = i_ref_valid & rd & ~i_io & ~i_pc_hit
              & ~i_bus_err;
        bpe_m = bpe & drd & i_bus_perr_req;
        bpe_i = bpe & ((drd & i_bus_perr_oth)
              | (ird & (i_bus_perr_req | i_bus_perr_oth)));
        ber_m = i_ref_valid & i_bus_err & (drd | i_cmd == CMD_WRITE
              | i_cmd == CMD_CLR_WBUF);
        ber_i = i_ref_valid & i_bus_err & ird;
        o_mchk = (tag & drd & i_pc_hit) | (dat & drd) | bpe_m | ber_m
               | i_fpa_perr;
        o_intr = tag | (dat & ird) | bpe_i | ber_i;
        o_desc_m = ({5{tag & drd & i_pc_hit}} & DESC_TAG)
                 | ({5{dat & drd}} & DESC_PDP)
                 | ({5{bpe_m}} & (DESC_DDP | backup_hit_flag))
                 | ({5{ber_m}} & (DESC_BER | backup_hit_flag));
        o_desc_i = ({5{tag}} & DESC_TAG)
                 | ({5{dat & ird}} & DESC_PDP)
                 | ({5{bpe_i}} & (DESC_DDP | backup_hit_flag))
                 | ({5{ber_i}} & (DESC_BER | backup_hit_flag));
    end
endmodule
`default_nettype wire

/* File: hw/lcerr_addr_latch.sv */
// holds the physical address of the failing reference
`timescale 1ns/1ps
`default_nettype none
module lcerr_addr_latch #(
    parameter int W = 30
) (
    input  wire logic         i_clk,
    input  wire logic         i_reset_n,
    input  wire logic         i_capture,
    input  wire logic [W-1:0] i_addr,
    output logic      [W-1:0] o_addr
);
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_addr <= '0;
        end else if (i_capture) begin
            o_addr <= i_addr;
        end
    end
endmodule
`default_nettype wire

/* File: hw/lcerr_top.sv */
// primary cache error latch: status register, traps and soft interrupt
`timescale 1ns/1ps
`default_nettype none
module lcerr_top import lcerr_pkg::*; #(
    parameter int ADDR_WIDTH = ADDR_W
) (
    input  wire logic                  i_clk,
    input  wire logic                  i_reset_n,
    input  wire logic                  i_ref_valid,
    input  wire lcerr_cmd_t            i_ref_cmd,
    input  wire logic                  i_ref_io,
    input  wire logic [ADDR_WIDTH-1:0] i_ref_addr,
    input  wire logic                  i_pc_hit,
    input  wire logic                  i_bc_hit,
    input  wire logic                  i_tag_perr,
    input  wire logic                  i_data_perr,
    input  wire logic                  i_bus_perr_req,
    input  wire logic                  i_bus_perr_oth,
    input  wire logic                  i_bus_err,
    input  wire logic                  i_fpa_perr,
    input  wire logic                  i_ipr_wr,
    input  wire logic                  i_ipr_rd,
    input  wire logic                  i_ipr_sel_sts,
    input  wire logic                  i_ipr_sel_err,
    input  wire logic [DATA_W-1:0]     i_ipr_wdata,
    output logic      [DATA_W-1:0]     o_ipr_rdata,
    output logic                       o_cache_on,
    output logic                       o_force_hit,
    output logic                       o_refresh_en,
    output logic                       o_flush,
    output logic                       o_soft_int_req,
    output logic      [4:0]            o_soft_int_ipl,
    output logic                       o_mchk
);
    logic                  fht_q;
    logic                  fht_d;
    logic                  pon_q;
    logic                  pon_d;
    logic                  rfr_q;
    logic                  rfr_d;
    logic                  hit_q;
    logic                  int_q;
    logic                  int_d;
    logic                  tr2_q;
    logic                  tr2_d;
    logic                  tr1_q;
    logic                  tr1_d;
    logic [DESC_W-1:0]     desc_q;
    logic [DESC_W-1:0]     desc_d;
    logic                  locked;
    logic                  sts_wr;
    logic [STS_W-1:0]      wr_bits;
    logic                  c_mchk;
    logic                  c_intr;
    logic [4:0]            c_desc_m;
    logic [4:0]            c_desc_i;
    logic                  mchk_first;
    logic                  mchk_repeat;
    logic                  int_load;
    logic [ADDR_WIDTH-1:0] err_addr;
    logic [STS_W-1:0]      sts_view;

    assign locked  = tr1_q | tr2_q | int_q;
    assign sts_wr  = i_ipr_wr & i_ipr_sel_sts;
    assign wr_bits = i_ipr_wdata[STS_W-1:0];

    lcerr_classify u_classify (
        .i_ref_valid    (i_ref_valid),
        .i_cmd          (i_ref_cmd),
        .i_io           (i_ref_io),
        .i_pc_hit       (i_pc_hit),
        .i_bc_hit       (i_bc_hit),
        .i_tag_perr     (i_tag_perr),
        .i_data_perr    (i_data_perr),
        .i_bus_perr_req (i_bus_perr_req),
        .i_bus_perr_oth (i_bus_perr_oth),
        .i_bus_err      (i_bus_err),
        .i_fpa_perr     (i_fpa_perr),
        .i_cache_en     (pon_q),
        .i_force_hit    (fht_q),
        .i_locked       (locked),
        .o_mchk         (c_mchk),
        .o_intr         (c_intr),
        .o_desc_m       (c_desc_m),
        .o_desc_i       (c_desc_i)
    );

    // trap outcome and interrupt capture decision
    assign mchk_first  = c_mchk & ~tr1_q;
    assign mchk_repeat = c_mchk & tr1_q;
    assign int_load    = c_intr & ~int_q & ~tr1_q
                       & ~mchk_first;

    lcerr_addr_latch #(
        .W (ADDR_WIDTH)
    ) u_addr (
        .i_clk     (i_clk),
        .i_reset_n (i_reset_n),
        .i_capture (mchk_first),
        .i_addr    (i_ref_addr),
        .o_addr    (err_addr)
    );

    // software controlled mode bits
    always_comb begin
        fht_d = fht_q;
        pon_d = pon_q;
        rfr_d = rfr_q;
        if (sts_wr) begin
            fht_d = wr_bits[BIT_FHT];
            pon_d = wr_bits[BIT_PON];
            rfr_d = wr_bits[BIT_RFR];
        end
    end

    // sticky flags; a hardware set beats a write-one clear
    always_comb begin
        tr1_d = tr1_q;
        tr2_d = tr2_q;
        int_d = int_q;
        if (sts_wr && wr_bits[BIT_TR1]) begin
            tr1_d = 1'b0;
        end
        if (sts_wr && wr_bits[BIT_TR2]) begin
            tr2_d = 1'b0;
        end
        if (sts_wr && wr_bits[BIT_INT]) begin
            int_d = 1'b0;
        end
        if (mchk_first) begin
            tr1_d = 1'b1;
        end
        if (mchk_repeat) begin
            tr2_d = 1'b1;
        end
        if (c_intr) begin
            int_d = 1'b1;
        end
    end

    // error description, bits 12:8
    always_comb begin
        desc_d = desc_q;
        if (sts_wr) begin
            desc_d = desc_q & ~wr_bits[STS_W-1:DESC_LSB];
        end
        if (mchk_first) begin
            desc_d = c_desc_m;
        end else if (int_load) begin
            desc_d = c_desc_i;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            fht_q <= 1'b0;
            pon_q <= 1'b0;
            rfr_q <= 1'b0;
        end else begin
            fht_q <= fht_d;
            pon_q <= pon_d;
            rfr_q <= rfr_d;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            tr1_q <= 1'b0;
            tr2_q <= 1'b0;
            int_q <= 1'b0;
        end else begin
            tr1_q <= tr1_d;
            tr2_q <= tr2_d;
            int_q <= int_d;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            desc_q <= DESC_RST;
        end else begin
            desc_q <= desc_d;
        end
    end

    // hit indication of the last reference
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            hit_q <= 1'b0;
        end else if (i_ref_valid) begin
            hit_q <= i_pc_hit;
        end
    end

    // outputs to the cache and the core
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_cache_on   <= 1'b0;
            o_force_hit  <= 1'b0;
            o_refresh_en <= 1'b0;
        end else begin
            o_cache_on   <= pon_d & ~(tr1_d | tr2_d | int_d);
            o_force_hit  <= fht_d;
            o_refresh_en <= rfr_d;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_flush <= 1'b0;
        end else begin
            o_flush <= sts_wr & wr_bits[BIT_FLS];
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_soft_int_req <= 1'b0;
            o_soft_int_ipl <= SOFT_IPL;
            o_mchk         <= 1'b0;
        end else begin
            o_soft_int_req <= int_d;
            o_soft_int_ipl <= SOFT_IPL;
            o_mchk         <= c_mchk;
        end
    end

    // register read, one cycle after the strobe
    always_comb begin
        sts_view = '0;
        sts_view[BIT_FHT] = fht_q;
        sts_view[BIT_PON] = pon_q;
        sts_view[BIT_RFR] = rfr_q;
        sts_view[BIT_HIT] = hit_q;
        sts_view[BIT_INT] = int_q;
        sts_view[BIT_TR2] = tr2_q;
        sts_view[BIT_TR1] = tr1_q;
        sts_view[STS_W-1:DESC_LSB] = desc_q;
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_ipr_rdata <= DATA_ZERO;
        end else if (i_ipr_rd) begin
            o_ipr_rdata <= DATA_ZERO;
            if (i_ipr_sel_sts) begin
                o_ipr_rdata[STS_W-1:0] <= sts_view;
            end else if (i_ipr_sel_err && tr1_q) begin
                o_ipr_rdata[ADDR_WIDTH-1:0] <= err_addr;
            end
        end
    end

    // checks
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_reset_n);

    sequence s_trap_then_repeat;
        mchk_first ##1 (c_mchk && !sts_wr);
    endsequence

    a_first_trap: assert property (
        mchk_first |=> tr1_q && o_mchk && desc_q == $past(c_desc_m)
            && err_addr == $past(i_ref_addr))
        else $error("first trap not captured");

    a_repeat_trap: assert property (
        s_trap_then_repeat |=> tr1_q && tr2_q && $stable(desc_q)
            && $stable(err_addr))
        else $error("repeat trap changed captured state");

    a_int_keeps_desc: assert property (
        c_intr && !c_mchk && (int_q || tr1_q) && !sts_wr
            |=> $stable(desc_q))
        else $error("interrupt overwrote description");

    a_int_sets_flag: assert property (
        c_intr |=> int_q && o_soft_int_req && o_soft_int_ipl == 5'h1a)
        else $error("interrupt flag not set");

    a_lock_disables: assert property (
        (tr1_q || tr2_q || int_q) |-> !o_cache_on)
        else $error("cache on while locked");

    a_epr_quiet: assert property (
        i_ref_valid && i_bus_err && !i_fpa_perr
            && (i_ref_cmd == CMD_EPR_READ || i_ref_cmd == CMD_IVEC_READ)
            |-> !c_mchk && !c_intr)
        else $error("register read bus error reported");

    a_fpa_trap: assert property (
        i_fpa_perr && !tr1_q |=> tr1_q)
        else $error("accelerator parity not a trap");

    a_tag_gated: assert property (
        i_tag_perr && (fht_q || !pon_q || locked)
            |-> c_desc_m[0] == 1'b0 && c_desc_i[0] == 1'b0)
        else $error("tag parity reported while gated");

    a_tag_dread: assert property (
        i_ref_valid && i_tag_perr && i_ref_cmd == CMD_D_READ && i_pc_hit
            && pon_q && !fht_q && !locked |-> c_mchk && c_intr)
        else $error("tag parity on data hit not both");

    a_idata_int: assert property (
        i_ref_valid && i_data_perr && i_ref_cmd == CMD_I_READ && i_pc_hit
            && pon_q && !fht_q |-> c_intr && c_desc_i[2])
        else $error("instruction data parity not interrupt");

    a_bus_perr_drop: assert property (
        i_bus_err |-> !c_desc_m[1] && !c_desc_i[1])
        else $error("bus parity taken on errored read");

    a_addr_locked: assert property (
        tr1_q && !(sts_wr && wr_bits[BIT_TR1]) |=> $stable(err_addr))
        else $error("error address moved while locked");

    a_trap_over_int: assert property (
        c_mchk && int_q && !tr1_q |=> tr1_q && desc_q == $past(c_desc_m))
        else $error("trap did not replace interrupt description");

    a_int_loads_desc: assert property (
        c_intr && !c_mchk && !int_q && !tr1_q
            |=> int_q && desc_q == $past(c_desc_i))
        else $error("interrupt description not loaded");

    a_bch_zero: assert property (
        i_ref_valid && !i_bus_err && !i_bus_perr_req && !i_bus_perr_oth
            |-> !c_desc_m[4] && !c_desc_i[4])
        else $error("backup hit shown for cache parity");

    a_inhibit_quiet: assert property (
        i_ref_valid && i_ref_cmd == CMD_OTHER && !i_fpa_perr
            |-> !c_mchk && !c_intr)
        else $error("inhibited command reported");

    a_mchk_quiet: assert property (
        !c_mchk |=> !o_mchk)
        else $error("machine check without error");
endmodule
`default_nettype wire

/* File: tb/lcerr_bus_model.sv */
// far-side model: cpu core references and local bus terminations
`timescale 1ns/1ps
`default_nettype none
module lcerr_bus_model import lcerr_pkg::*; (
    input  wire logic        i_clk,
    output var  logic        o_ref_valid,
    output var  lcerr_cmd_t  o_ref_cmd,
    output var  logic        o_ref_io,
    output var  logic [29:0] o_ref_addr,
    output var  logic        o_pc_hit,
    output var  logic        o_bc_hit,
    output var  logic        o_tag_perr,
    output var  logic        o_data_perr,
    output var  logic        o_bus_perr_req,
    output var  logic        o_bus_perr_oth,
    output var  logic        o_bus_err,
    output var  logic        o_fpa_perr
);
    // flag bits: 0 fpa, 1 bus err, 2 other lw, 3 req lw, 4 data,
    // 5 tag, 6 backup hit, 7 primary hit, 8 io
    task automatic idle();
        o_ref_valid    = 1'b0;
        o_ref_cmd      = CMD_OTHER;
        o_ref_io       = ~o_ref_io;
        o_ref_addr     = ~o_ref_addr;
        o_pc_hit       = ~o_pc_hit;
        o_bc_hit       = ~o_bc_hit;
        o_tag_perr     = 1'b0;
        o_data_perr    = 1'b0;
        o_bus_perr_req = 1'b0;
        o_bus_perr_oth = 1'b0;
        o_bus_err      = 1'b0;
        o_fpa_perr     = 1'b0;
    endtask

    // one reference, held standing when the call returns
    task automatic hold_ref(input lcerr_cmd_t c, input logic [9:0] f,
                            input logic [29:0] a);
        o_ref_valid    = ~f[0];
        o_ref_cmd      = c;
        o_ref_io       = f[8];
        o_ref_addr     = a;
        o_pc_hit       = f[7];
        o_bc_hit       = f[6];
        o_tag_perr     = f[5];
        o_data_perr    = f[4];
        o_bus_perr_req = f[3];
        o_bus_perr_oth = f[2];
        o_bus_err      = f[1];
        o_fpa_perr     = f[0];
        @(negedge i_clk);
    endtask

    // one reference, entered just after a falling edge, then idle
    task automatic do_ref(input lcerr_cmd_t c, input logic [9:0] f,
                          input logic [29:0] a);
        hold_ref(c, f, a);
        idle();
    endtask

    initial begin
        o_ref_io   = 1'b0;
        o_ref_addr = 30'h0000_0000;
        o_pc_hit   = 1'b0;
        o_bc_hit   = 1'b0;
        idle();
    end
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// self-checking bench of the primary cache error latch
`timescale 1ns/1ps
`default_nettype none
module tb_top import lcerr_pkg::*; ;
    localparam logic [9:0] F_FPA = 10'h001;
    localparam logic [9:0] F_BE  = 10'h002;
    localparam logic [9:0] F_BPO = 10'h004;
    localparam logic [9:0] F_BPR = 10'h008;
    localparam logic [9:0] F_DP  = 10'h010;
    localparam logic [9:0] F_TAG = 10'h020;
    localparam logic [9:0] F_BCH = 10'h040;
    localparam logic [9:0] F_PCH = 10'h080;
    localparam logic [9:0] F_IO  = 10'h100;
    localparam logic [9:0] F_FH  = 10'h200;

    logic        i_clk;
    logic        i_reset_n;
    logic        ref_valid, ref_io, pc_hit, bc_hit, tag_perr, data_perr;
    logic        bus_perr_req, bus_perr_oth, bus_err, fpa_perr;
    lcerr_cmd_t  ref_cmd;
    logic [29:0] ref_addr;
    logic        i_ipr_wr, i_ipr_rd, i_ipr_sel_sts, i_ipr_sel_err;
    logic [31:0] i_ipr_wdata;
    logic [31:0] o_ipr_rdata;
    logic        o_cache_on, o_force_hit, o_refresh_en, o_flush;
    logic        o_soft_int_req, o_mchk;
    logic [4:0]  o_soft_int_ipl;
    int          err_total;
    int          checks;

    lcerr_bus_model lcerr_bus_model_inst (
        .i_clk(i_clk), .o_ref_valid(ref_valid), .o_ref_cmd(ref_cmd),
        .o_ref_io(ref_io), .o_ref_addr(ref_addr), .o_pc_hit(pc_hit),
        .o_bc_hit(bc_hit), .o_tag_perr(tag_perr), .o_data_perr(data_perr),
        .o_bus_perr_req(bus_perr_req), .o_bus_perr_oth(bus_perr_oth),
        .o_bus_err(bus_err), .o_fpa_perr(fpa_perr));

    lcerr_top lcerr_top_inst (
        .i_clk(i_clk), .i_reset_n(i_reset_n), .i_ref_valid(ref_valid),
        .i_ref_cmd(ref_cmd), .i_ref_io(ref_io), .i_ref_addr(ref_addr),
        .i_pc_hit(pc_hit), .i_bc_hit(bc_hit), .i_tag_perr(tag_perr),
        .i_data_perr(data_perr), .i_bus_perr_req(bus_perr_req),
        .i_bus_perr_oth(bus_perr_oth), .i_bus_err(bus_err),
        .i_fpa_perr(fpa_perr), .i_ipr_wr(i_ipr_wr), .i_ipr_rd(i_ipr_rd),
        .i_ipr_sel_sts(i_ipr_sel_sts), .i_ipr_sel_err(i_ipr_sel_err),
        .i_ipr_wdata(i_ipr_wdata), .o_ipr_rdata(o_ipr_rdata),
        .o_cache_on(o_cache_on), .o_force_hit(o_force_hit),
        .o_refresh_en(o_refresh_en), .o_flush(o_flush),
        .o_soft_int_req(o_soft_int_req), .o_soft_int_ipl(o_soft_int_ipl),
        .o_mchk(o_mchk));

    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end

    task automatic end_of_test();
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] got,
                         input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // status write, entered and left just after a falling edge
    task automatic wr_sts(input logic [31:0] d);
        @(negedge i_clk);
        i_ipr_wr      = 1'b1;
        i_ipr_sel_sts = 1'b1;
        i_ipr_wdata   = d;
        @(negedge i_clk);
        i_ipr_wr      = 1'b0;
        i_ipr_sel_sts = 1'b0;
        i_ipr_wdata   = ~d;
    endtask

    // register read; bit 4 of status is masked by the caller
    task automatic rd_chk(input string nm, input logic ss, input logic se,
                          input logic [31:0] exp, input logic [31:0] msk);
        @(negedge i_clk);
        i_ipr_rd      = 1'b1;
        i_ipr_sel_sts = ss;
        i_ipr_sel_err = se;
        @(negedge i_clk);
        i_ipr_rd      = 1'b0;
        i_ipr_sel_sts = 1'b0;
        i_ipr_sel_err = 1'b0;
        check(nm, o_ipr_rdata & msk, exp);
    endtask

    // clear flags, one reference, then check outputs and both registers
    task automatic run_case(input lcerr_cmd_t c, input logic [9:0] f,
                            input logic [4:0] desc, input logic tr1,
                            input logic intr);
        logic [29:0] a;
        logic [31:0] es;
        a  = {20'h2b5c3, f};
        es = {19'h0, desc, tr1, 1'b0, intr, 1'b0, 3'h5, f[9]};
        wr_sts(32'h0000_1fea | {31'h0, f[9]});
        lcerr_bus_model_inst.do_ref(c, f, a);
        check("mchk", {31'h0, o_mchk}, {31'h0, tr1});
        check("soft_int", {31'h0, o_soft_int_req}, {31'h0, intr});
        check("cache_on", {31'h0, o_cache_on}, {31'h0, ~(tr1 | intr)});
        check("force_hit", {31'h0, o_force_hit}, {31'h0, f[9]});
        check("refresh", {31'h0, o_refresh_en}, 32'h1);
        rd_chk("status", 1'b1, 1'b0, es, 32'h0000_1fef);
        rd_chk("err_addr", 1'b0, 1'b1, tr1 ? {2'h0, a} : 32'h0, 32'hffff_ffff);
    endtask

    initial begin
        err_total     = 0;
        checks        = 0;
        i_reset_n     = 1'b0;
        i_ipr_wr      = 1'b0;
        i_ipr_rd      = 1'b0;
        i_ipr_sel_sts = 1'b0;
        i_ipr_sel_err = 1'b0;
        i_ipr_wdata   = 32'h0000_0000;
        repeat (8) @(posedge i_clk);
        @(negedge i_clk);
        i_reset_n = 1'b1;
        @(negedge i_clk);
        check("ipl", {27'h0, o_soft_int_ipl}, 32'h0000_001a);
        rd_chk("status_rst", 1'b1, 1'b0, 32'h0, 32'hffff_ffff);
        run_case(CMD_D_READ, F_TAG | F_PCH | F_BCH, 5'h01, 1'b1, 1'b1);
        run_case(CMD_D_READ, F_TAG, 5'h01, 1'b0, 1'b1);
        run_case(CMD_I_READ, F_TAG | F_PCH, 5'h01, 1'b0, 1'b1);
        run_case(CMD_WRITE, F_TAG, 5'h01, 1'b0, 1'b1);
        run_case(CMD_INVAL, F_TAG, 5'h01, 1'b0, 1'b1);
        run_case(CMD_OTHER, F_TAG, 5'h00, 1'b0, 1'b0);
        run_case(CMD_D_READ, F_DP | F_PCH | F_BCH, 5'h04, 1'b1, 1'b0);
        run_case(CMD_I_READ, F_DP | F_PCH, 5'h04, 1'b0, 1'b1);
        run_case(CMD_D_READ, F_DP, 5'h00, 1'b0, 1'b0);
        run_case(CMD_D_READ, F_DP | F_PCH | F_FH, 5'h00, 1'b0, 1'b0);
        run_case(CMD_D_READ, F_BPR | F_BCH, 5'h12, 1'b1, 1'b0);
        run_case(CMD_D_READ, F_BPO | F_BCH, 5'h12, 1'b0, 1'b1);
        run_case(CMD_I_READ, F_BPR, 5'h02, 1'b0, 1'b1);
        run_case(CMD_D_READ, F_BPR | F_IO, 5'h00, 1'b0, 1'b0);
        run_case(CMD_D_READ, F_BPR | F_PCH, 5'h00, 1'b0, 1'b0);
        run_case(CMD_D_READ, F_BE | F_BPR | F_BCH, 5'h18, 1'b1, 1'b0);
        run_case(CMD_I_READ, F_BE, 5'h08, 1'b0, 1'b1);
        run_case(CMD_WRITE, F_BE | F_BCH, 5'h18, 1'b1, 1'b0);
        run_case(CMD_CLR_WBUF, F_BE, 5'h08, 1'b1, 1'b0);
        run_case(CMD_EPR_READ, F_BE, 5'h00, 1'b0, 1'b0);
        run_case(CMD_IVEC_READ, F_BE, 5'h00, 1'b0, 1'b0);
        run_case(CMD_RSLT_XFER, F_FPA, 5'h00, 1'b1, 1'b0);
        // double errors without clearing in between
        wr_sts(32'h0000_1fea);
        lcerr_bus_model_inst.hold_ref(CMD_I_READ, F_DP | F_PCH, 30'h0000_1110);
        lcerr_bus_model_inst.do_ref(CMD_I_READ, F_BPO, 30'h0000_1120);
        rd_chk("sts_int2", 1'b1, 1'b0, 32'h0000_042a, 32'h0000_1fef);
        lcerr_bus_model_inst.do_ref(CMD_WRITE, F_BE, 30'h0000_2220);
        check("mchk_1", {31'h0, o_mchk}, 32'h1);
        rd_chk("sts_trap", 1'b1, 1'b0, 32'h0000_08aa, 32'h0000_1fef);
        lcerr_bus_model_inst.hold_ref(CMD_D_READ, F_DP | F_PCH, 30'h0000_3330);
        check("mchk_2", {31'h0, o_mchk}, 32'h1);
        lcerr_bus_model_inst.do_ref(CMD_WRITE, F_TAG, 30'h0000_4440);
        rd_chk("sts_repeat_machine_check_flag", 1'b1, 1'b0, 32'h0000_08ea, 32'h0000_1fef);
        rd_chk("addr_kept", 1'b0, 1'b1, 32'h0000_2220, 32'hffff_ffff);
        wr_sts(32'h0000_1fee);
        check("flush", {31'h0, o_flush}, 32'h1);
        rd_chk("sts_clear", 1'b1, 1'b0, 32'h0000_000a, 32'h0000_1fef);
        check("cache_back", {31'h0, o_cache_on}, 32'h1);
        // two traps on consecutive cycles
        lcerr_bus_model_inst.hold_ref(CMD_D_READ, F_BPR, 30'h0000_5550);
        lcerr_bus_model_inst.do_ref(CMD_WRITE, F_BE, 30'h0000_6660);
        check("mchk_3", {31'h0, o_mchk}, 32'h1);
        rd_chk("sts_2trap", 1'b1, 1'b0, 32'h0000_02ca, 32'h0000_1fef);
        rd_chk("addr_first", 1'b0, 1'b1, 32'h0000_5550, 32'hffff_ffff);
        end_of_test();
    end

    initial begin
        repeat (20000) @(posedge i_clk);
        err_total++;
        $display("Error watchdog expected end seen timeout");
        end_of_test();
    end
endmodule
`default_nettype wire
